// >>> shared/radio_cfg_pkg.sv
// constants and types shared by the modem configuration and status bank
package radio_cfg_pkg;

  // register offsets
  localparam logic [7:0] STRENGTH_CLEAR_OFFSET = 8'h13;
  localparam logic [7:0] FRAME_SYNC_OFFSET     = 8'h14;
  localparam logic [7:0] TRANSMIT_CTRL_OFFSET  = 8'h15;
  localparam logic [7:0] RECEIVE_BIAS_OFFSET   = 8'h16;

  // field positions
  localparam int THR_LSB        = 8;
  localparam int VAL_LSB        = 0;
  localparam int TX_BUF_LSB     = 14;
  localparam int TX_DELAY_BIT   = 13;
  localparam int TX_MIXCAP_LSB  = 11;
  localparam int TX_MIXCUR_LSB  = 9;
  localparam int AMP_TRIM_LSB   = 6;
  localparam int AMP_DIFF_BIT   = 5;
  localparam int AMP_LEVEL_LSB  = 0;
  localparam int RX_BUF_LSB     = 12;
  localparam int COMP_HIGH_LSB  = 10;
  localparam int COMP_MED_LSB   = 8;
  localparam int COMP_LOW_LSB   = 6;
  localparam int BIAS_HIGH_LSB  = 4;
  localparam int BIAS_MED_LSB   = 2;
  localparam int BIAS_LOW_LSB   = 0;

  // reset values
  localparam logic [7:0]  THR_RESET      = 8'hE0;
  localparam logic [7:0]  STRENGTH_RESET = 8'h80;
  localparam logic [15:0] SYNC_RESET     = 16'hA70F;
  localparam logic [15:0] TXC_RESET      = 16'h60FF;
  localparam logic [13:0] RXC_RESET      = 14'h12E5;

  // sync pattern symbols
  localparam logic [3:0] SKIP_NIBBLE = 4'hF;
  localparam logic [3:0] ZERO_SYMBOL = 4'h0;

  // timing
  localparam int CLK_MHZ        = 20;
  localparam int SYMBOL_US      = 16;
  localparam int DELAY_SHORT_US = 128;
  localparam int DELAY_LONG_US  = 192;
  localparam int SYMBOL_CYCLES  = SYMBOL_US * CLK_MHZ;
  localparam int SHORT_CYCLES   = DELAY_SHORT_US * CLK_MHZ;
  localparam int LONG_CYCLES    = DELAY_LONG_US * CLK_MHZ;

  typedef enum logic [1:0] {
    GAIN_LOW  = 2'b00,
    GAIN_MED  = 2'b01,
    GAIN_HIGH = 2'b10
  } gain_mode_t;

  typedef enum logic [1:0] {
    CRIT_RESERVED = 2'b00,
    CRIT_LEVEL    = 2'b01,
    CRIT_NO_FRAME = 2'b10,
    CRIT_BOTH     = 2'b11
  } criterion_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SYNC = 2'b10
  } tx_state_t;

endpackage

// >>> src/strength_averager.sv
// signal strength averager over the latest symbol periods with valid flag
`timescale 1ns/10ps
`default_nettype none
module strength_averager
  import radio_cfg_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // sampling
  input  wire logic       sample_tick,
  input  wire logic       rx_enable,
  input  wire logic [7:0] raw_strength,
  // result
  output logic      [7:0] value,
  output logic            valid,
  output logic            update
);
  localparam int LG = $clog2(DEPTH);
  localparam int SW = 8 + LG;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] hist;
    logic [LG:0]           cnt;
    logic [7:0]            value;
    logic                  valid;
    logic                  update;
  } avg_t;

  avg_t q_r;
  avg_t q_nxt;
  logic signed [SW-1:0] sum;

  always_comb
  begin
    q_nxt = q_r;
    sum = '0;
    q_nxt.update = 1'b0;
    if (!rx_enable)
    begin
      q_nxt.cnt   = '0;
      q_nxt.value = STRENGTH_RESET;
      q_nxt.valid = 1'b0;
    end
    else if (sample_tick)
    begin
      q_nxt.hist = {q_r.hist[DEPTH-2:0], raw_strength};
      if (q_r.cnt != (LG+1)'(DEPTH))
        q_nxt.cnt = q_r.cnt + 1'b1;
      for (int i = 0; i < DEPTH; i++)
        sum = sum + SW'($signed(q_nxt.hist[i]));
      if (q_nxt.cnt == (LG+1)'(DEPTH))
      begin
        q_nxt.value  = sum[SW-1 -: 8];
        q_nxt.valid  = 1'b1;
        q_nxt.update = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      q_r <= '{hist: '0, cnt: '0, value: STRENGTH_RESET, valid: 1'b0, update: 1'b0};
    else
      q_r <= q_nxt;
  end

  assign value  = q_r.value;
  assign valid  = q_r.valid;
  assign update = q_r.update;
endmodule // strength_averager
`default_nettype wire

// >>> src/sync_detector.sv
// frame sync detector: required nibbles after an implicit zero
`timescale 1ns/10ps
`default_nettype none
module sync_detector
  import radio_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // demodulated symbols
  input  wire logic        rx_enable,
  input  wire logic [3:0]  symbol,
  input  wire logic        symbol_valid,
  input  wire logic [15:0] pattern,
  // result
  output logic             found
);
  typedef struct packed {
    logic [4:0][3:0] hist;
    logic [2:0]      fill;
    logic            found;
  } det_t;

  det_t q_r;
  det_t q_nxt;
  logic [4:0][3:0] expect_sym;
  logic [2:0]      need;
  logic            match;

  always_comb
  begin
    q_nxt = q_r;
    expect_sym = '0;
    need = '0;
    match = 1'b1;
    q_nxt.found = 1'b0;
    // newest first: highest required nibble down to the implicit zero
    for (int i = 3; i >= 0; i--)
      if (pattern[4*i +: 4] != SKIP_NIBBLE)
      begin
        expect_sym[need] = pattern[4*i +: 4];
        need = need + 3'd1;
      end
    expect_sym[need] = ZERO_SYMBOL;
    need = need + 3'd1;
    if (!rx_enable)
      q_nxt.fill = '0;
    else if (symbol_valid)
    begin
      q_nxt.hist = {q_r.hist[3:0], symbol};
      if (q_r.fill != 3'd5)
        q_nxt.fill = q_r.fill + 3'd1;
      for (int k = 0; k < 5; k++)
        if (k < int'(need) && q_nxt.hist[k] != expect_sym[k])
          match = 1'b0;
      q_nxt.found = match && (q_nxt.fill >= need);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign found = q_r.found;
endmodule // sync_detector
`default_nettype wire

// >>> src/radio_modem_config_status_regs.sv
// modem configuration and status register bank with clear-channel logic
//
// Notes on behaviour
// - Clear threshold: signed 8 bits, 1 dB, same offset as strength, resets -32.
// - Clear pin high while received strength sits below the threshold.
// - Read-only signed strength estimate, averaged over last 8 symbols.
// - Strength valid flag only after receiver enabled 8 symbol periods; here valid on the 8th free-running symbol tick, 7 to 8 periods after enable.
// - Strength estimate resets to -128, meaning invalid.
// - Sync pattern 16 bits, resets 0xA70F, used lowest nibble first.
// - Transmitted sync nibbles equal to 0xF are sent as zero.
// - Received sync nibbles equal to 0xF are not required.
// - Reception needs an implicit zero before first required sync symbol.
// - Transmit waits 8 symbols (bit 0) or 12 symbols (bit 1).
// - Five-bit amplifier level, resets 31, drives transmit level.
// - Amplifier output type bit: 1 differential, 0 single-ended, resets 1.
// - Three-bit amplifier trim, resets 3, nominal at 3.
// - Two-bit transmit mixer buffer bias, resets 1, nominal.
// - Main front amp bias per gain mode; active mode's code applied.
// - Compensation code per gain mode; high mode code 0 disables.
// - Criterion: below threshold minus hysteresis, no frame, or both.
// - Hysteresis of 0 to 7 dB applies to clear decision.
`timescale 1ns/10ps
`default_nettype none
module radio_modem_config_status_regs
  import radio_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // register port from the serial interface
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // clear-channel configuration
  input  wire logic [1:0]  clear_criterion_select,
  input  wire logic [2:0]  clear_hysteresis,
  // receiver side
  input  wire logic        rx_enable,
  input  wire logic [7:0]  raw_strength,
  input  wire logic        frame_receiving,
  input  wire logic [3:0]  rx_symbol,
  input  wire logic        rx_symbol_valid,
  input  wire logic [1:0]  gain_mode,
  // transmitter side
  input  wire logic        transmit_on_command,
  // status outputs
  output logic             channel_clear_flag,
  output logic             strength_valid_flag,
  output logic             sync_found,
  // transmit sequencing
  output logic             tx_start,
  output logic             tx_busy,
  output logic [3:0]       tx_symbol,
  output logic             tx_symbol_strobe,
  // analog settings
  output logic [4:0]       amp_output_level,
  output logic             amp_differential_select,
  output logic [2:0]       amp_bias_trim,
  output logic [1:0]       transmit_mixer_buffer_bias,
  output logic [1:0]       tx_mixer_cap,
  output logic [1:0]       tx_mixer_current,
  output logic [1:0]       rx_mixer_buffer_bias,
  output logic [1:0]       front_amp_main_bias,
  output logic [1:0]       front_amp_comp,
  output logic             front_amp_comp_enable
);
  typedef struct packed {
    logic [7:0]  thr;
    logic [15:0] sync;
    logic [15:0] txc;
    logic [13:0] rxc;
    logic        clear;
    logic [15:0] rdata;
    tx_state_t   st;
    logic [11:0] wait_cnt;
    logic [8:0]  tick_cnt;
    logic        tick;
    logic [8:0]  sym_cnt;
    logic [1:0]  nib_idx;
    logic [3:0]  tx_sym;
    logic        tx_strobe;
    logic        tx_start;
    logic [1:0]  bias;
    logic [1:0]  comp;
    logic        comp_en;
    logic        busy;
  } bank_t;

  localparam logic [8:0]  SYM_LAST   = 9'(SYMBOL_CYCLES - 1);
  localparam logic [11:0] SHORT_LAST = 12'(SHORT_CYCLES - 1);
  localparam logic [11:0] LONG_LAST  = 12'(LONG_CYCLES - 1);

  bank_t q_r;
  bank_t q_nxt;

  logic [7:0] strength_value;
  logic       strength_valid;
  logic       strength_update;
  logic       found;

  logic signed [9:0] level;
  logic signed [9:0] low_mark;
  logic              below_low;
  logic              at_or_above;
  logic [3:0]        nib;
  logic [1:0]        comp_sel;

  strength_averager #(
    .DEPTH (8)
  ) u_avg (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .sample_tick  (q_r.tick),
    .rx_enable    (rx_enable),
    .raw_strength (raw_strength),
    .value        (strength_value),
    .valid        (strength_valid),
    .update       (strength_update)
  );

  sync_detector u_sync (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .rx_enable    (rx_enable),
    .symbol       (rx_symbol),
    .symbol_valid (rx_symbol_valid),
    .pattern      (q_r.sync),
    .found        (found)
  );

  // substitutes the zero symbol for a skipped sync nibble
  function automatic logic [3:0] tx_nibble(input logic [15:0] pat,
                                           input logic [1:0]  idx);
    logic [3:0] n;
    n = pat[4*idx +: 4];
    return (n == SKIP_NIBBLE) ? ZERO_SYMBOL : n;
  endfunction

  always_comb
  begin
    q_nxt = q_r;
    q_nxt.tx_start  = 1'b0;
    q_nxt.tx_strobe = 1'b0;
    q_nxt.tick      = 1'b0;

    // symbol period timebase for the averager
    if (q_r.tick_cnt == SYM_LAST)
    begin
      q_nxt.tick_cnt = '0;
      q_nxt.tick     = 1'b1;
    end
    else
      q_nxt.tick_cnt = q_r.tick_cnt + 9'd1;

    // register writes; reserved top bits of receive bias are not stored
    if (reg_wr)
    begin
      case (reg_addr)
        STRENGTH_CLEAR_OFFSET: q_nxt.thr  = reg_wdata[THR_LSB +: 8];
        FRAME_SYNC_OFFSET:     q_nxt.sync = reg_wdata;
        TRANSMIT_CTRL_OFFSET:  q_nxt.txc  = reg_wdata;
        RECEIVE_BIAS_OFFSET:   q_nxt.rxc  = reg_wdata[13:0];
        default:               q_nxt.thr  = q_r.thr;
      endcase
    end

    // registered read data, unmapped offsets read zero
    if (reg_rd)
    begin
      case (reg_addr)
        STRENGTH_CLEAR_OFFSET: q_nxt.rdata = {q_r.thr, strength_value};
        FRAME_SYNC_OFFSET:     q_nxt.rdata = q_r.sync;
        TRANSMIT_CTRL_OFFSET:  q_nxt.rdata = q_r.txc;
        RECEIVE_BIAS_OFFSET:   q_nxt.rdata = {2'b00, q_r.rxc};
        default:               q_nxt.rdata = 16'h0000;
      endcase
    end

    // clear-channel decision, re-evaluated against the latest estimate
    level       = 10'(signed'(strength_value));
    low_mark    = 10'(signed'(q_r.thr)) - 10'(clear_hysteresis);
    below_low   = level < low_mark;
    at_or_above = level >= 10'(signed'(q_r.thr));
    case (clear_criterion_select)
      CRIT_LEVEL:
      begin
        if (below_low)
          q_nxt.clear = 1'b1;
        else if (at_or_above)
          q_nxt.clear = 1'b0;
      end
      CRIT_NO_FRAME:
        q_nxt.clear = !frame_receiving;
      CRIT_BOTH:
      begin
        if (at_or_above || frame_receiving)
          q_nxt.clear = 1'b0;
        else if (below_low)
          q_nxt.clear = 1'b1;
      end
      default:
        q_nxt.clear = q_r.clear;
    endcase

    // transmit start delay and sync nibble sequence
    nib = '0;
    case (q_r.st)
      TX_IDLE:
      begin
        if (transmit_on_command)
        begin
          q_nxt.st = TX_WAIT;
          q_nxt.wait_cnt = q_r.txc[TX_DELAY_BIT] ? LONG_LAST : SHORT_LAST;
        end
      end
      TX_WAIT:
      begin
        if (q_r.wait_cnt == 12'd0)
        begin
          q_nxt.st        = TX_SYNC;
          q_nxt.tx_start  = 1'b1;
          q_nxt.nib_idx   = 2'd0;
          q_nxt.sym_cnt   = '0;
          q_nxt.tx_sym    = tx_nibble(q_r.sync, 2'd0);
          q_nxt.tx_strobe = 1'b1;
        end
        else
          q_nxt.wait_cnt = q_r.wait_cnt - 12'd1;
      end
      TX_SYNC:
      begin
        if (q_r.sym_cnt == SYM_LAST)
        begin
          q_nxt.sym_cnt = '0;
          if (q_r.nib_idx == 2'd3)
            q_nxt.st = TX_IDLE;
          else
          begin
            q_nxt.nib_idx   = q_r.nib_idx + 2'd1;
            q_nxt.tx_sym    = tx_nibble(q_r.sync, q_r.nib_idx + 2'd1);
            q_nxt.tx_strobe = 1'b1;
          end
        end
        else
          q_nxt.sym_cnt = q_r.sym_cnt + 9'd1;
      end
      default:
        q_nxt.st = TX_IDLE;
    endcase

    // front amp settings for the active gain mode
    case (gain_mode)
      GAIN_HIGH:
      begin
        q_nxt.bias = q_r.rxc[BIAS_HIGH_LSB +: 2];
        comp_sel   = q_r.rxc[COMP_HIGH_LSB +: 2];
      end
      GAIN_MED:
      begin
        q_nxt.bias = q_r.rxc[BIAS_MED_LSB +: 2];
        comp_sel   = q_r.rxc[COMP_MED_LSB +: 2];
      end
      default:
      begin
        q_nxt.bias = q_r.rxc[BIAS_LOW_LSB +: 2];
        comp_sel   = q_r.rxc[COMP_LOW_LSB +: 2];
      end
    endcase
    q_nxt.comp    = comp_sel;
    q_nxt.comp_en = !(gain_mode == GAIN_HIGH && comp_sel == 2'd0);
    nib = q_nxt.tx_sym;
    q_nxt.tx_sym = nib;
    q_nxt.busy = (q_nxt.st != TX_IDLE);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q_r      <= '0;
      q_r.thr  <= THR_RESET;
      q_r.sync <= SYNC_RESET;
      q_r.txc  <= TXC_RESET;
      q_r.rxc  <= RXC_RESET;
      q_r.st   <= TX_IDLE;
      q_r.clear <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  assign reg_rdata                  = q_r.rdata;
  assign channel_clear_flag         = q_r.clear;
  assign strength_valid_flag        = strength_valid;
  assign sync_found                 = found;
  assign tx_start                   = q_r.tx_start;
  assign tx_busy                    = q_r.busy;
  assign tx_symbol                  = q_r.tx_sym;
  assign tx_symbol_strobe           = q_r.tx_strobe;
  assign amp_output_level           = q_r.txc[AMP_LEVEL_LSB +: 5];
  assign amp_differential_select    = q_r.txc[AMP_DIFF_BIT];
  assign amp_bias_trim              = q_r.txc[AMP_TRIM_LSB +: 3];
  assign transmit_mixer_buffer_bias = q_r.txc[TX_BUF_LSB +: 2];
  assign tx_mixer_cap               = q_r.txc[TX_MIXCAP_LSB +: 2];
  assign tx_mixer_current           = q_r.txc[TX_MIXCUR_LSB +: 2];
  assign rx_mixer_buffer_bias       = q_r.rxc[RX_BUF_LSB +: 2];
  assign front_amp_main_bias        = q_r.bias;
  assign front_amp_comp             = q_r.comp;
  assign front_amp_comp_enable      = q_r.comp_en;
endmodule // radio_modem_config_status_regs
`default_nettype wire

// >>> dv/host_port_model.sv
// host side of the register port: one-cycle write and read strobes
`timescale 1ns/10ps
`default_nettype none
module host_port_model
  import radio_cfg_pkg::*;
(
  // clock
  input  wire logic        core_clk,
  // register port
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // released lines carry the inverse, not a stale copy
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= (a == RECEIVE_BIAS_OFFSET) ? {2'b00, d[13:0]} : d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule // host_port_model
`default_nettype wire

// >>> dv/radio_modem_config_status_regs_checker.sv
// concurrent checks on the configuration and status bank ports
`timescale 1ns/10ps
`default_nettype none
module radio_modem_config_status_regs_checker
  import radio_cfg_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // receiver and clear channel
  input wire logic [1:0]  clear_criterion_select,
  input wire logic        frame_receiving,
  input wire logic        rx_enable,
  input wire logic [1:0]  gain_mode,
  input wire logic        channel_clear_flag,
  input wire logic        strength_valid_flag,
  input wire logic [1:0]  front_amp_comp,
  input wire logic        front_amp_comp_enable,
  // transmit
  input wire logic        tx_busy,
  input wire logic        tx_start,
  input wire logic [3:0]  tx_symbol,
  input wire logic        tx_symbol_strobe
);
  typedef struct packed {
    logic [12:0] busy;
    logic [12:0] en;
  } cnt_t;
  cnt_t cnt_r;
  cnt_t cnt_nxt;

  // cycles of busy and of receiver enable
  always_comb
  begin
    cnt_nxt      = cnt_r;
    cnt_nxt.busy = tx_busy ? cnt_r.busy + 13'h0001 : 13'h0000;
    cnt_nxt.en   = !rx_enable ? 13'h0000 : (&cnt_r.en ? cnt_r.en : cnt_r.en + 13'h0001);
  end

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_TX_DELAY:
    assert property (tx_start |-> (cnt_r.busy == SHORT_CYCLES || cnt_r.busy == LONG_CYCLES))
      else $error("transmit start at wrong delay");
  AST_TX_GAP:
    assert property (tx_symbol_strobe |=> !tx_symbol_strobe [*8])
      else $error("symbol strobes too close");
  AST_TX_NO_SKIP:
    assert property (tx_symbol_strobe |-> tx_symbol != SKIP_NIBBLE)
      else $error("skip nibble transmitted");
  AST_VALID_WAIT:
    assert property (strength_valid_flag |-> cnt_r.en >= 7 * SYMBOL_CYCLES)
      else $error("strength valid too early");
  AST_VALID_DROP:
    assert property (!rx_enable |=> !strength_valid_flag)
      else $error("strength valid with receiver off");
  AST_CLEAR_FRAME:
    assert property (clear_criterion_select[1] && frame_receiving |=> !channel_clear_flag)
      else $error("clear flag high during frame");
  AST_CLEAR_IDLE:
    assert property (clear_criterion_select == CRIT_NO_FRAME && !frame_receiving
                     |=> channel_clear_flag)
      else $error("clear flag low without frame");
  AST_CLEAR_HOLD:
    assert property ($stable(clear_criterion_select) && clear_criterion_select == CRIT_RESERVED
                     |=> $stable(channel_clear_flag))
      else $error("clear flag moved in reserved mode");
  AST_STRENGTH_IDLE:
    assert property (reg_rd && reg_addr == STRENGTH_CLEAR_OFFSET && !rx_enable && !$past(rx_enable)
                     |=> reg_rdata[7:0] == STRENGTH_RESET)
      else $error("idle strength not invalid code");
  AST_COMP_HIGH:
    assert property (gain_mode == GAIN_HIGH |=> front_amp_comp_enable == (front_amp_comp != 2'h0))
      else $error("high gain compensation enable wrong");
endmodule // radio_modem_config_status_regs_checker
`default_nettype wire

// >>> dv/tb_radio_modem_config_status_regs.sv
// self-checking bench for the modem configuration and status bank
`timescale 1ns/10ps
`default_nettype none
module tb_radio_modem_config_status_regs
  import radio_cfg_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic w; logic [15:0] d; logic [15:0] e;} row_t;
  typedef struct packed {logic [1:0] c; logic [2:0] h; logic [7:0] t; logic f; logic e;} clr_t;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic        reg_wr, reg_rd;
  logic [1:0]  crit = 2'h0;
  logic [2:0]  hyst = 3'h0;
  logic        rx_en = 1'b0, frame = 1'b0, sym_v = 1'b0, tx_cmd = 1'b0;
  logic [7:0]  raw = 8'hD8;
  logic [3:0]  rx_sym = 4'h0;
  logic [1:0]  gain = 2'h0;
  logic        clear_f, valid_f, found, tx_start, tx_busy, tx_strb, fa_en, diff;
  logic [3:0]  tx_sym;
  logic [4:0]  lvl;
  logic [2:0]  trim;
  logic [1:0]  mixbuf, fa_bias, fa_comp;
  int          miscompares = 0, checked = 0, hits = 0, n;
  logic [4:0]  fexp [3] = '{5'h1D, 5'h19, 5'h02};
  logic [3:0]  syms [6] = '{4'h7, 4'h5, 4'h3, 4'h0, 4'h5, 4'h3};
  row_t rows [10] = '{'{8'h13, 1'b0, 16'h0000, 16'hE0D8}, '{8'h14, 1'b0, 16'h0000, 16'hA70F},
    '{8'h15, 1'b0, 16'h0000, 16'h60FF}, '{8'h16, 1'b0, 16'h0000, 16'h12E5},
    '{8'h17, 1'b0, 16'h0000, 16'h0000}, '{8'h13, 1'b1, 16'h1234, 16'h12D8},
    '{8'h14, 1'b1, 16'h3F5F, 16'h3F5F}, '{8'h15, 1'b1, 16'h1F55, 16'h1F55},
    '{8'h16, 1'b1, 16'hFFFF, 16'h3FFF}, '{8'h17, 1'b1, 16'hFFFF, 16'h0000}};
  clr_t ctab [9] = '{'{2'h1, 3'h3, 8'hC0, 1'b0, 1'b0}, '{2'h1, 3'h3, 8'hDA, 1'b0, 1'b0},
    '{2'h1, 3'h1, 8'hDA, 1'b0, 1'b1}, '{2'h3, 3'h0, 8'hDA, 1'b1, 1'b0},
    '{2'h2, 3'h0, 8'hDA, 1'b0, 1'b1}, '{2'h2, 3'h0, 8'hDA, 1'b1, 1'b0},
    '{2'h3, 3'h0, 8'hDA, 1'b0, 1'b1}, '{2'h3, 3'h0, 8'hC0, 1'b0, 1'b0},
    '{2'h0, 3'h0, 8'h7F, 1'b0, 1'b0}};

  always #25 core_clk = ~core_clk;

  always @(posedge core_clk)
    if (found === 1'b1)
      hits <= hits + 1;

  host_port_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  radio_modem_config_status_regs u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clear_criterion_select(crit), .clear_hysteresis(hyst),
    .rx_enable(rx_en), .raw_strength(raw), .frame_receiving(frame), .rx_symbol(rx_sym),
    .rx_symbol_valid(sym_v), .gain_mode(gain), .transmit_on_command(tx_cmd),
    .channel_clear_flag(clear_f), .strength_valid_flag(valid_f), .sync_found(found),
    .tx_start(tx_start), .tx_busy(tx_busy), .tx_symbol(tx_sym), .tx_symbol_strobe(tx_strb),
    .amp_output_level(lvl), .amp_differential_select(diff), .amp_bias_trim(trim),
    .transmit_mixer_buffer_bias(mixbuf), .tx_mixer_cap(), .tx_mixer_current(),
    .rx_mixer_buffer_bias(), .front_amp_main_bias(fa_bias), .front_amp_comp(fa_comp),
    .front_amp_comp_enable(fa_en));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_hi(input string what, ref logic sig, input int lim);
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (sig !== 1'b1 && n < lim);
    if (sig !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %s expected 1 seen timeout", what);
      give_verdict();
    end
  endtask

  task automatic send_sym(input logic [3:0] s);
    @(posedge core_clk);
    rx_sym <= s;
    sym_v  <= 1'b1;
    @(posedge core_clk);
    sym_v  <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic run_tx(input int dly, input logic [15:0] exp);
    logic [15:0] got;
    @(posedge core_clk);
    tx_cmd <= 1'b1;
    @(posedge core_clk);
    tx_cmd <= 1'b0;
    wait_hi("tx start", tx_start, dly + 4);
    chk("tx delay", 16'(n), 16'(dly));
    got[3:0] = tx_sym;
    for (int k = 1; k < 4; k++)
    begin
      wait_hi("tx strobe", tx_strb, SYMBOL_CYCLES + 4);
      got[k*4 +: 4] = tx_sym;
    end
    chk("tx symbols", got, exp);
    repeat (SYMBOL_CYCLES + 4) @(posedge core_clk);
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("reset pins", {12'h0, clear_f, valid_f, found, tx_busy}, 16'h0008);
    chk("tx fields", {5'h0, mixbuf, trim, diff, lvl}, 16'h02FF);
    for (int g = 0; g < 3; g++)
    begin
      @(posedge core_clk);
      gain <= 2'(g);
      repeat (2) @(posedge core_clk);
      #1;
      chk("front amp", {11'h0, fa_en, fa_comp, fa_bias}, {11'h0, fexp[g]});
    end
    @(posedge core_clk);
    rx_en <= 1'b1;
    wait_hi("valid", valid_f, 8 * SYMBOL_CYCLES + 4);
    chk("valid wait", {15'h0, n >= 7 * SYMBOL_CYCLES}, 16'h0001);
    foreach (rows[i])
    begin
      if (rows[i].w)
        u_host.write_reg(rows[i].a, rows[i].d);
      u_host.read_reg(rows[i].a, rd);
      chk($sformatf("reg %h", rows[i].a), rd, rows[i].e);
    end
    chk("tx fields", {5'h0, mixbuf, trim, diff, lvl}, 16'h0155);
    $display("test done: registers");
    foreach (ctab[i])
    begin
      u_host.write_reg(STRENGTH_CLEAR_OFFSET, {ctab[i].t, 8'h00});
      crit  <= ctab[i].c;
      hyst  <= ctab[i].h;
      frame <= ctab[i].f;
      repeat (3) @(posedge core_clk);
      #1;
      chk("clear flag", {15'h0, clear_f}, {15'h0, ctab[i].e});
    end
    $display("test done: clear channel");
    @(posedge core_clk);
    raw <= 8'hE8;
    repeat (8 * SYMBOL_CYCLES + 4) @(posedge core_clk);
    u_host.read_reg(STRENGTH_CLEAR_OFFSET, rd);
    chk("strength avg", rd, 16'h7FE8);
    foreach (syms[i])
    begin
      send_sym(syms[i]);
      if (i == 2)
        chk("sync early", 16'(hits), 16'h0000);
    end
    chk("sync found", 16'(hits), 16'h0001);
    $display("test done: strength and sync");
    run_tx(SHORT_CYCLES, 16'h3050);
    u_host.write_reg(TRANSMIT_CTRL_OFFSET, 16'h3F55);
    run_tx(LONG_CYCLES, 16'h3050);
    $display("test done: transmit");
    @(posedge core_clk);
    rx_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    u_host.read_reg(STRENGTH_CLEAR_OFFSET, rd);
    chk("idle strength", {rd[7:0], 7'h0, valid_f}, 16'h8000);
    $display("test done: receiver off");
    give_verdict();
  end
endmodule // tb_radio_modem_config_status_regs

bind radio_modem_config_status_regs radio_modem_config_status_regs_checker u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clear_criterion_select(clear_criterion_select),
  .frame_receiving(frame_receiving), .rx_enable(rx_enable), .gain_mode(gain_mode),
  .channel_clear_flag(channel_clear_flag), .strength_valid_flag(strength_valid_flag),
  .front_amp_comp(front_amp_comp), .front_amp_comp_enable(front_amp_comp_enable),
  .tx_busy(tx_busy), .tx_start(tx_start), .tx_symbol(tx_symbol),
  .tx_symbol_strobe(tx_symbol_strobe));
`default_nettype wire
